// ### pkg/ssle_cfg.svh
/*
 * Constants of the shading and streak erase block: register offsets,
 * field positions, line layout and thresholds.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef SSLE_CFG_SVH
`define SSLE_CFG_SVH
// Register byte offsets
`define SSLE_OFS_CTRL 4'h0
`define SSLE_OFS_SET 4'h4
`define SSLE_OFS_STAT 4'h8
`define SSLE_OFS_BLACK 4'hC
// Control bits (JOB, PAGE and STOP write one, self clearing; FEEDER holds its written value)
`define SSLE_CTRL_JOB 0
`define SSLE_CTRL_PAGE 1
`define SSLE_CTRL_STOP 2
`define SSLE_CTRL_FEEDER 3
// Line layout and shading
`define SSLE_DARK_PIX 9'h020
`define SSLE_LINE_PIX 9'h100
`define SSLE_SHADE_LINES 3'h4
`define SSLE_LAMP_MIN 8'h40
`define SSLE_STREAK_MAX 4'h6
`define SSLE_DARK_W12 4'h4
// Streak thresholds per level
`define SSLE_WTHR_1 8'h40
`define SSLE_WTHR_2 8'h20
`define SSLE_BTHR_1 8'h50
`define SSLE_BTHR_2 8'h38
`define SSLE_BTHR_3 8'h20
`define SSLE_FULL6 6'h3F
`endif

// ### pkg/ssle_pkg.sv
/*
 * Types of the shading and streak erase block.
 * Assumes nothing of its surroundings.
 */
package ssle_pkg;
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		SSLE_IDLE = 5'h01,
		SSLE_SHADE = 5'h02,
		SSLE_READY = 5'h04,
		SSLE_SCAN = 5'h08,
		SSLE_FAULT = 5'h10
	} ssle_state_t;
endpackage : ssle_pkg

// ### src/ssle_top.sv
/*
 * Shading correction and streak erase for a line sensor stream, with an
 * output FIFO. Assumes pixels arrive asynchronously (synchronised here),
 * each line opening with its dark dummy pixels, and a software port on clk.
 */
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "ssle_cfg.svh"

// ****************************************
// Output FIFO
// ****************************************
module ssle_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;

	// Full and empty from pointer wrap bits
	assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData = mem[rdPtr_q[AW-1:0]];

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	// Pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_q + (AW+1)'(push);
			rdPtr_q <= rdPtr_q + (AW+1)'(pop);
		end
	end
endmodule : ssle_fifo

module ssle_top
	import ssle_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic [7:0] sensPix,
	input wire logic sensValid,
	input wire logic sensLast,
	output logic [7:0] pixOut,
	output logic pixOutLast,
	output logic pixOutValid,
	input wire logic pixOutReady,
	output logic lampFault
);
	// ****************************************
	// Input synchroniser
	// ****************************************
	logic [9:0] sync1_q;
	logic [9:0] sync2_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {sensLast, sensValid, sensPix};
			sync2_q <= sync1_q;
		end
	end
	wire [7:0] pix = sync2_q[7:0];
	wire pixValid = sync2_q[8];
	wire pixLast = sync2_q[9];

	// ****************************************
	// Registers
	// ****************************************
	ssle_state_t state_q;
	ssle_state_t state_d;
	logic [1:0] whiteLvl_q;
	logic [1:0] darkLvl_q;
	logic [3:0] density_q;
	logic [1:0] origMode_q;
	logic feeder_q;
	logic reshade_q;
	logic overrun_q;
	logic fault_q;
	logic [7:0] black_q;
	logic [7:0] whiteMax_q;
	logic [31:0] rdData_q;
	wire selCtrl = regAddr == `SSLE_OFS_CTRL;
	wire selSet = regAddr == `SSLE_OFS_SET;
	wire selStat = regAddr == `SSLE_OFS_STAT;
	wire selBlack = regAddr == `SSLE_OFS_BLACK;
	wire wrCtrl = regWr && selCtrl;
	wire wrSet = regWr && selSet;
	wire jobGo = wrCtrl && regWrData[`SSLE_CTRL_JOB];
	wire pageDone = wrCtrl && regWrData[`SSLE_CTRL_PAGE];
	wire stopGo = wrCtrl && regWrData[`SSLE_CTRL_STOP];
	wire setChange = wrSet && ((regWrData[11:8] != density_q) || (regWrData[13:12] != origMode_q));
	wire [31:0] setWord = {18'h0, origMode_q, density_q, 4'h0, darkLvl_q, whiteLvl_q};
	wire [31:0] statWord = {8'h0, whiteMax_q, 8'h0, reshade_q, overrun_q, fault_q, state_q};
	wire [31:0] rdMux = selCtrl ? {28'h0, feeder_q, 3'h0} :
		selSet ? setWord :
		selStat ? statWord :
		selBlack ? {24'h0, black_q} : 32'h0;

	// Settings and read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			whiteLvl_q <= 2'h1;
			darkLvl_q <= 2'h1;
			density_q <= 4'h0;
			origMode_q <= 2'h0;
			feeder_q <= 1'b0;
			rdData_q <= 32'h0;
		end else begin
			if (wrSet) begin
				whiteLvl_q <= regWrData[1:0];
				darkLvl_q <= regWrData[3:2];
				density_q <= regWrData[11:8];
				origMode_q <= regWrData[13:12];
			end
			if (wrCtrl) begin
				feeder_q <= regWrData[`SSLE_CTRL_FEEDER];
			end
			rdData_q <= regRd ? rdMux : 32'h0;
		end
	end

	// ****************************************
	// Line position and black level
	// ****************************************
	logic [8:0] pixCnt_q;
	logic [12:0] darkSum_q;
	wire inDark = pixCnt_q < `SSLE_DARK_PIX;
	wire [8:0] imgIdx9 = pixCnt_q - `SSLE_DARK_PIX;
	wire [7:0] imgIdx = imgIdx9[7:0];
	wire inImage = !inDark && (imgIdx9 < `SSLE_LINE_PIX);
	wire [12:0] darkNext = darkSum_q + {5'h0, pix};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pixCnt_q <= 9'h0;
			darkSum_q <= 13'h0;
			black_q <= 8'h0;
		end else if (pixValid) begin
			pixCnt_q <= pixLast ? 9'h0 : (inImage || inDark ? pixCnt_q + 9'h1 : pixCnt_q);
			if (inDark) begin
				darkSum_q <= (pixCnt_q == 9'h0) ? {5'h0, pix} : darkNext;
			end
			if (pixCnt_q == `SSLE_DARK_PIX - 9'h1) begin
				black_q <= darkNext[12:5];
			end
		end
	end

	// ****************************************
	// White shading store
	// ****************************************
	logic [9:0] shadeMem [256];
	logic [2:0] shadeLine_q;
	logic shadeArm_q;
	wire [9:0] shadeRd = shadeMem[imgIdx];
	wire capture = (state_q == SSLE_SHADE) && shadeArm_q && pixValid && inImage;
	wire [9:0] shadeSum = (shadeLine_q == 3'h0) ? {2'h0, pix} : shadeRd + {2'h0, pix};
	wire lastShadeLine = shadeLine_q == `SSLE_SHADE_LINES - 3'h1;
	wire shadeDone = (state_q == SSLE_SHADE) && shadeArm_q && pixValid && pixLast && lastShadeLine;
	wire peakUp = capture && lastShadeLine && (shadeSum[9:2] > whiteMax_q);
	wire [7:0] peakNow = peakUp ? shadeSum[9:2] : whiteMax_q; // Peak including this pixel
	always_ff @(posedge clk) begin
		if (capture) begin
			shadeMem[imgIdx] <= shadeSum;
		end
	end

	// Capture line count and white peak
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shadeLine_q <= 3'h0;
			shadeArm_q <= 1'b0;
			whiteMax_q <= 8'h0;
		end else if (state_q != SSLE_SHADE) begin
			shadeLine_q <= 3'h0;
			shadeArm_q <= 1'b0;
			if (state_d == SSLE_SHADE) whiteMax_q <= 8'h0; // Peak readable until next capture
		end else if (pixValid) begin
			if (pixLast) begin
				shadeArm_q <= 1'b1;
				shadeLine_q <= shadeArm_q ? shadeLine_q + 3'h1 : 3'h0;
			end
			if (peakUp) begin
				whiteMax_q <= shadeSum[9:2];
			end
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			SSLE_IDLE: begin
				if (jobGo) state_d = SSLE_SHADE;
			end
			SSLE_SHADE: begin
				if (shadeDone) begin
					state_d = (peakNow <= `SSLE_LAMP_MIN) ? SSLE_FAULT : SSLE_READY;
				end
			end
			SSLE_READY: begin
				if (reshade_q) state_d = SSLE_SHADE;
				else if (pixValid && pixLast) state_d = SSLE_SCAN;
			end
			SSLE_SCAN: begin
				if (pageDone) state_d = SSLE_SHADE;
			end
			SSLE_FAULT: begin
				if (jobGo) state_d = SSLE_SHADE;
			end
			default: state_d = SSLE_IDLE;
		endcase
		if (stopGo) state_d = SSLE_IDLE;
	end

	// State, reshade request and fault flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SSLE_IDLE;
			reshade_q <= 1'b0;
			fault_q <= 1'b0;
			lampFault <= 1'b0;
		end else begin
			state_q <= state_d;
			if (setChange && state_q != SSLE_IDLE) reshade_q <= 1'b1;
			else if (state_q == SSLE_SHADE) reshade_q <= 1'b0;
			if (state_d == SSLE_FAULT) fault_q <= 1'b1;
			else if (jobGo || stopGo) fault_q <= 1'b0;
			lampFault <= state_d == SSLE_FAULT;
		end
	end

	// ****************************************
	// Black subtraction and white scaling
	// ****************************************
	wire [7:0] whiteAvg = shadeRd[9:2];
	wire [7:0] vSub = (pix > black_q) ? pix - black_q : 8'h0;
	wire [7:0] wSub = (whiteAvg > black_q) ? whiteAvg - black_q : 8'h0;
	wire [5:0] v6 = vSub[7:2];
	wire [5:0] w6 = wSub[7:2];
	wire [11:0] scaled = (w6 == 6'h0) ? 12'h03F : ({6'h0, v6} * 12'h03F) / {6'h0, w6};
	wire [5:0] norm6 = (scaled > {6'h0, `SSLE_FULL6}) ? `SSLE_FULL6 : scaled[5:0];
	wire [7:0] corr = {norm6, norm6[5:4]};
	wire scanPix = (state_q == SSLE_SCAN) && pixValid && inImage;

	// ****************************************
	// Streak erase window of thirteen pixels
	// ****************************************
	logic [7:0] win_q [13];
	logic [12:0] winLast_q;
	logic [12:0] winFull_q;
	logic stageValid_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 13; i++) win_q[i] <= 8'h0;
			winLast_q <= 13'h0;
			winFull_q <= 13'h0;
			stageValid_q <= 1'b0;
		end else begin
			stageValid_q <= scanPix && winFull_q[5];
			if (scanPix) begin
				win_q[0] <= corr;
				for (int i = 1; i < 13; i++) win_q[i] <= win_q[i-1];
				winLast_q <= {winLast_q[11:0], pixLast};
				winFull_q <= {winFull_q[11:0], 1'b1};
			end
		end
	end

	// Neighbour comparison per tap, centre is tap 6
	wire [7:0] ctr = win_q[6];
	wire [7:0] wThr = (whiteLvl_q == 2'h1) ? `SSLE_WTHR_1 : `SSLE_WTHR_2;
	wire [7:0] bThr = (darkLvl_q == 2'h1) ? `SSLE_BTHR_1 :
		(darkLvl_q == 2'h2) ? `SSLE_BTHR_2 : `SSLE_BTHR_3;
	wire [3:0] bMaxW = (darkLvl_q == 2'h3) ? `SSLE_STREAK_MAX : `SSLE_DARK_W12;
	logic [12:0] darker;
	logic [12:0] lighter;
	genvar g;
	generate
		for (g = 0; g < 13; g++) begin : g_tap
			assign darker[g] = {1'b0, win_q[g]} + {1'b0, wThr} <= {1'b0, ctr};
			assign lighter[g] = {1'b0, ctr} + {1'b0, bThr} <= {1'b0, win_q[g]};
		end
	endgenerate

	// Nearest bounding pixel on each side
	logic [3:0] wL, wR, bL, bR;
	always_comb begin
		wL = 4'h0;
		wR = 4'h0;
		bL = 4'h0;
		bR = 4'h0;
		for (int j = 6; j >= 1; j--) begin
			if (darker[6+j]) wL = 4'(j);
			if (darker[6-j]) wR = 4'(j);
			if (lighter[6+j]) bL = 4'(j);
			if (lighter[6-j]) bR = 4'(j);
		end
	end
	wire [4:0] wWidth = {1'b0, wL} + {1'b0, wR} - 5'h1;
	wire [4:0] bWidth = {1'b0, bL} + {1'b0, bR} - 5'h1;
	wire wHit = (whiteLvl_q != 2'h0) && (wL != 4'h0) && (wR != 4'h0)
		&& (wWidth <= {1'b0, `SSLE_STREAK_MAX});
	wire bHit = (darkLvl_q != 2'h0) && feeder_q && (bL != 4'h0) && (bR != 4'h0)
		&& (bWidth <= {1'b0, bMaxW});
	// Bounds averaged at six bits, then widened like a corrected pixel
	wire [6:0] wFill = {1'b0, win_q[4'd6 + wL][7:2]} + {1'b0, win_q[4'd6 - wR][7:2]};
	wire [6:0] bFill = {1'b0, win_q[4'd6 + bL][7:2]} + {1'b0, win_q[4'd6 - bR][7:2]};
	wire [5:0] fill6 = wHit ? wFill[6:1] : bFill[6:1];
	wire [7:0] erased = (wHit || bHit) ? {fill6, fill6[5:4]} : ctr;

	// ****************************************
	// Output FIFO and output register
	// ****************************************
	logic fifoInReady;
	logic fifoOutValid;
	logic [8:0] fifoOutData;
	wire outLoad = !pixOutValid || pixOutReady;
	ssle_fifo #(.WIDTH(9), .DEPTH(16)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(stageValid_q),
		.inReady(fifoInReady),
		.inData({winLast_q[6], erased}),
		.outValid(fifoOutValid),
		.outReady(outLoad),
		.outData(fifoOutData)
	);

	// Registered output and overrun flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pixOut <= 8'h0;
			pixOutLast <= 1'b0;
			pixOutValid <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			if (outLoad) begin
				pixOutValid <= fifoOutValid;
				pixOut <= fifoOutData[7:0];
				pixOutLast <= fifoOutData[8];
			end
			if (stageValid_q && !fifoInReady) overrun_q <= 1'b1;
			else if (jobGo) overrun_q <= 1'b0;
		end
	end
	assign regRdData = rdData_q;
endmodule : ssle_top

// ### tb/ssle_assertions.sv
/* Checker of the ssle_top ports: register answers and output stream.
 * Assumes it is bound into every ssle_top instance. */
`timescale 1ns/1ns
// ****************
// Port checker
// ****************
module ssle_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	input wire logic [7:0] sensPix,
	input wire logic sensValid,
	input wire logic sensLast,
	input wire logic [7:0] pixOut,
	input wire logic pixOutLast,
	input wire logic pixOutValid,
	input wire logic pixOutReady,
	input wire logic lampFault
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Register access steps
	sequence setWrite; regWr && regAddr == 4'h4; endsequence
	sequence setRead; regRd && !regWr && regAddr == 4'h4; endsequence
	sequence statRead; regRd && regAddr == 4'h8; endsequence
	a_set_read_back: assert property (setWrite ##1 setRead |=>
		regRdData[13:0] == ($past(regWrData[13:0], 2) & 14'h3F0F)) else $error("settings read back wrong");
	a_fault_flag_state: assert property (statRead |=> regRdData[5] == regRdData[4])
		else $error("fault flag differs from state");
	a_fault_weak_peak: assert property (statRead ##1 regRdData[4] |-> regRdData[23:16] <= 8'h40)
		else $error("fault with strong white peak");
	a_ready_strong_peak: assert property (statRead ##1 (regRdData[3:2] != 2'h0) |-> regRdData[23:16] > 8'h40)
		else $error("scan allowed with weak white peak");
	a_lamp_pin_state: assert property (statRead ##1 regRdData[5] |-> lampFault)
		else $error("lamp fault pin low in fault");
	a_state_one_hot: assert property (statRead |=> $onehot(regRdData[4:0]))
		else $error("state not one hot");
	a_out_hold: assert property (pixOutValid && !pixOutReady |=>
		pixOutValid && $stable(pixOut) && $stable(pixOutLast)) else $error("output pixel dropped while stalled");
	a_six_bit_out: assert property (pixOutValid |-> pixOut[1:0] == pixOut[7:6])
		else $error("output not six bit widened");
endmodule : ssle_checker

bind ssle_top ssle_checker chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sensPix(sensPix), .sensValid(sensValid),
	.sensLast(sensLast), .pixOut(pixOut), .pixOutLast(pixOutLast), .pixOutValid(pixOutValid),
	.pixOutReady(pixOutReady), .lampFault(lampFault));

// ### tb/ssle_sensor_model.sv
/* Sensor digitiser model: lines of dark dummies, then image pixels.
 * Assumes clk is the block clock; data change after rising edges. */
`timescale 1ns/1ns
module ssle_sensor_model (
	input wire logic clk,
	output logic [7:0] sensPix,
	output logic sensValid,
	output logic sensLast
);
	// Idle at time zero
	initial begin
		sensPix = 8'h00;
		sensValid = 1'b0;
		sensLast = 1'b0;
	end
	// One line, optional streak at image pixel 100, then a gap
	task automatic send_line(input logic [7:0] dark, input logic [7:0] img, input logic [7:0] strk, input int w);
		for (int i = 0; i < 288; i++) begin
			@(posedge clk);
			sensValid <= 1'b1;
			sensLast <= (i == 287);
			sensPix <= i < 32 ? dark : (i >= 132 && i < 132 + w) ? strk : img;
		end
		@(posedge clk);
		sensValid <= 1'b0;
		sensLast <= 1'b0;
		repeat (8) begin
			@(posedge clk);
			sensPix <= ~sensPix;
		end
	endtask : send_line
endmodule : ssle_sensor_model

// ### tb/tb.sv
/* Self-checking bench of ssle_top: registers, shading, streak erase, overrun, lamp fault.
 * Assumes the sensor model drives the pixel inputs. */
`timescale 1ns/1ns
module tb;
	logic clk, rst_n, regWr, regRd, pixOutReady, sensValid, sensLast, pixOutLast, pixOutValid, lampFault;
	logic [3:0] regAddr;
	logic [31:0] regWrData, regRdData, rdv;
	logic [7:0] sensPix, pixOut;
	logic [7:0] outMem [0:4095];
	int lastAt [$];
	int miscompares = 0, n_compared = 0, nOut = 0, qs, e1, e2;
	ssle_top uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .sensPix(sensPix), .sensValid(sensValid), .sensLast(sensLast),
		.pixOut(pixOut), .pixOutLast(pixOutLast), .pixOutValid(pixOutValid), .pixOutReady(pixOutReady),
		.lampFault(lampFault));
	ssle_sensor_model sens (.clk(clk), .sensPix(sensPix), .sensValid(sensValid), .sensLast(sensLast));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Record taken pixels and line ends
	always @(posedge clk) begin
		if (pixOutValid && pixOutReady) begin
			outMem[nOut[11:0]] <= pixOut;
			if (pixOutLast)
				lastAt.push_back(nOut);
			nOut <= nOut + 1;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		rdv = regRdData;
	endtask : rd
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	task automatic wait_lines(input int n);
		int k;
		for (k = 0; k < 3000 && lastAt.size() < n; k++)
			@(posedge clk);
		if (k == 3000) begin
			miscompares++;
			$display("wrong value at %0t: output lines missing", $time);
			print_verdict();
		end
	endtask : wait_lines
	// Reset values, unmapped read, back to back write and read
	task automatic t_regs();
		rd(4'h4);
		chk(rdv, 32'h5);
		rd(4'h8);
		chk(rdv[4:0], 5'h01);
		rd(4'h1);
		chk(rdv, 32'h0);
		@(posedge clk);
		regAddr <= 4'h4;
		regWrData <= 32'hD;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(regRdData, 32'hD);
		wr(4'h4, 32'h5);
		$display("test regs done");
	endtask : t_regs
	// Shading, correction, streak widths, black level, overrun, reshade
	task automatic t_scan();
		wr(4'h0, 32'h1);
		repeat (6) sens.send_line(8'h10, 8'hF0, 8'hF0, 0);
		rd(4'h8);
		chk(rdv[4:0], 5'h08);
		chk(rdv[23:16], 8'hF0);
		qs = lastAt.size();
		sens.send_line(8'h10, 8'h88, 8'h88, 0);
		sens.send_line(8'h10, 8'h88, 8'hF0, 3);
		sens.send_line(8'h10, 8'h88, 8'hF0, 7);
		wr(4'h0, 32'h8);
		wr(4'h4, 32'hD);
		sens.send_line(8'h10, 8'h88, 8'h60, 6);
		wr(4'h4, 32'h5);
		sens.send_line(8'h10, 8'h88, 8'h40, 5);
		sens.send_line(8'h10, 8'h88, 8'h60, 2);
		sens.send_line(8'h10, 8'h88, 8'hA8, 2);
		wr(4'h4, 32'h6);
		sens.send_line(8'h10, 8'h88, 8'hA8, 2);
		sens.send_line(8'h10, 8'h88, 8'h88, 0);
		wait_lines(qs + 8);
		e1 = lastAt[qs + 1];
		e2 = lastAt[qs + 2];
		chk(lastAt[qs], 32'hFF);
		chk(outMem[e1 - 205], 8'h86);
		chk(outMem[e1 - 154], 8'h86);
		chk(outMem[e2 - 152], 8'hFF);
		chk(outMem[lastAt[qs + 3] - 153], 8'h86);
		chk(outMem[lastAt[qs + 4] - 153], 8'h34);
		chk(outMem[lastAt[qs + 5] - 155], 8'h59);
		chk(outMem[lastAt[qs + 6] - 155], 8'hAA);
		chk(outMem[lastAt[qs + 7] - 155], 8'h86);
		rd(4'hC);
		chk(rdv[7:0], 8'h10);
		@(posedge clk);
		pixOutReady <= 1'b0;
		sens.send_line(8'h10, 8'h88, 8'h88, 0);
		rd(4'h8);
		chk(rdv[6], 1'b1);
		@(posedge clk);
		pixOutReady <= 1'b1;
		wr(4'h4, 32'h105);
		rd(4'h8);
		chk(rdv[7], 1'b1);
		$display("test scan done");
	endtask : t_scan
	// Page end reshade with a weak white plate
	task automatic t_fault();
		wr(4'h0, 32'h2);
		repeat (5) sens.send_line(8'h00, 8'h40, 8'h40, 0);
		chk(lampFault, 1'b1);
		rd(4'h8);
		chk(rdv[5:0], 6'h30);
		chk(rdv[23:16], 8'h40);
		wr(4'h0, 32'h4);
		rd(4'h8);
		chk(rdv[5:0], 6'h01);
		chk(lampFault, 1'b0);
		$display("test fault done");
	endtask : t_fault
	// Main sequence
	initial begin
		rst_n = 1'b0;
		regAddr = 4'h0;
		regWrData = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		pixOutReady = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_scan();
		t_fault();
		print_verdict();
	end
endmodule : tb
